/* verilog/fbalsm_pkg.sv */
package fbalsm_pkg;
    // Register offsets in the interface memory
    localparam logic [15:0] STATE_REQUEST_OFS    = 16'h0120;
    localparam logic [15:0] STATE_REPORT_OFS     = 16'h0130;
    localparam logic [15:0] STATE_ERROR_CODE_OFS = 16'h0134;

    // Field positions shared by request and report words
    localparam int STATE_LSB = 0;
    localparam int STATE_MSB = 3;
    localparam int FLAG_BIT  = 4;

    // State encodings, identical in request and report
    localparam logic [3:0] ST_INIT   = 4'h1;
    localparam logic [3:0] ST_PREOP  = 4'h2;
    localparam logic [3:0] ST_BOOT   = 4'h3;
    localparam logic [3:0] ST_SAFEOP = 4'h4;
    localparam logic [3:0] ST_OP     = 4'h8;

    // The only error codes ever produced
    localparam logic [15:0] CODE_NONE     = 16'h0000;
    localparam logic [15:0] CODE_BADTRANS = 16'h0011;
    localparam logic [15:0] CODE_BADSYNC  = 16'h0017;

    // Reset values
    localparam logic [15:0] REPORT_RST = 16'h0001;
    localparam logic [15:0] CODE_RST   = 16'h0000;

    // Sync-manager configuration as presented to the block
    typedef struct packed {
        logic [15:0] startAddr;
        logic [15:0] length;
    } fbalsm_smcfg_s;

    // Answer words written back to the interface memory
    typedef struct packed {
        logic [15:0] report;
        logic [15:0] code;
    } fbalsm_answer_s;
endpackage

/* verilog/fbalsm_top.sv */
// Behaviour
// - Only a rising edge of control bit 4 counts as fault acknowledgement.
// - Current state reported in status bits 3:0 at 0x0130, same encoding.
// - Status bit 4 is zero on accepted change, one on failed change.
// - Error code register at 0x0134 is 16 bits; 0x0000 means no error.
// - Forbidden transitions keep state, set error flag, report code 0x0011.
// - Bad sync-manager setup on init-preop or preop-safeop gives code 0x0017.
// - Only the three defined error codes ever appear.
// - Init: no mailbox, no cyclic traffic, configuration-memory emulation on.
// - Preop: mailbox channel active.
// - Safeop: cyclic actual values sent, synchronisation attempted.
// - Op: setpoints processed, torque enable allowed, synchronised required.
// - Init-preop checks sync managers 0 and 1, then arms sync manager 0 events.
// - Preop-safeop checks sync managers 2 and 3 start address and length.
// - Safeop-op enables the sync manager 2 hardware interrupt.
// - Any exit from op disables the sync manager 2 hardware interrupt.
// - Master writes only control; device writes only status and error code.
// - Every new non-zero request written is answered in both status and error code.
// - Control changes are found by polling, not by interrupt.
module fbalsm_top #(
    parameter logic [15:0] SM_MIN_ADDR = 16'h1000, // Lowest legal buffer start
    parameter logic [15:0] SM_MAX_LEN  = 16'h0200  // Largest legal buffer length
)(
    input  wire logic                    mclk,        // System clock, 250 MHz
    input  wire logic                    srst,        // Synchronous reset, high
    input  wire logic [15:0]             ctrlWord,    // Control register contents
    input  wire fbalsm_pkg::fbalsm_smcfg_s smCfg0,    // Sync manager 0 setup
    input  wire fbalsm_pkg::fbalsm_smcfg_s smCfg1,    // Sync manager 1 setup
    input  wire fbalsm_pkg::fbalsm_smcfg_s smCfg2,    // Sync manager 2 setup
    input  wire fbalsm_pkg::fbalsm_smcfg_s smCfg3,    // Sync manager 3 setup
    input  wire logic                    inSync,      // Drive synchronised to network
    output logic [15:0]                  stateReport, // Status register contents
    output logic [15:0]                  errorCode,   // Error code register contents
    output logic                         answerWe,    // Pulse: status and code written
    output logic                         mailboxEn,   // Mailbox channel active
    output logic                         cyclicInEn,  // Cyclic actual values active
    output logic                         cyclicOutEn, // Cyclic setpoints processed
    output logic                         torqueAllow, // Torque enable permitted
    output logic                         eepromEmuEn, // Config-memory emulation on
    output logic                         sm0EventEn,  // Sync manager 0 events armed
    output logic                         sm2IrqEn,    // Sync manager 2 interrupt on
    output logic                         syncSeek     // Synchronisation attempted
);

    // Elaboration check: a zero length limit would refuse every buffer
    if (SM_MAX_LEN == 16'h0000)
    begin : g_len_check
        $error("SM_MAX_LEN must be non-zero");
    end

    typedef enum logic [2:0] {S_INIT, S_PREOP, S_BOOT, S_SAFEOP, S_OP} fbalsm_state_e;

    // Buffer check: start inside window, non-zero length that fits
    function automatic logic smOk(input fbalsm_pkg::fbalsm_smcfg_s c);
        logic [16:0] endAddr;
        endAddr = {1'b0, c.startAddr} + {1'b0, c.length};
        smOk = (c.startAddr >= SM_MIN_ADDR) && (c.length != 16'h0000)
            && (c.length <= SM_MAX_LEN) && !endAddr[16];
    endfunction

    // Encode a state for the report field
    function automatic logic [3:0] stCode(input fbalsm_state_e s);
        case (s)
            S_INIT:   stCode = fbalsm_pkg::ST_INIT;
            S_PREOP:  stCode = fbalsm_pkg::ST_PREOP;
            S_BOOT:   stCode = fbalsm_pkg::ST_BOOT;
            S_SAFEOP: stCode = fbalsm_pkg::ST_SAFEOP;
            S_OP:     stCode = fbalsm_pkg::ST_OP;
            default:  stCode = fbalsm_pkg::ST_INIT;
        endcase
    endfunction

    fbalsm_state_e state;
    fbalsm_state_e next_state;
    logic [15:0]   ctrlQ1;
    logic [15:0]   ctrlQ2;
    logic [15:0]   ctrlQ3;
    logic          ctrlStable;
    logic [3:0]    lastReq;
    logic          lastAck;
    logic          errFlag;
    logic          next_errFlag;
    logic [15:0]   next_code;
    logic          reqSeen;
    logic          ackRise;
    logic [3:0]    req;
    logic          validReq;

    // Control word crosses in from the master side: two stages first.
    // Bits may settle in different cycles, so a third stage lets the
    // word be acted on only once it has read the same twice in a row.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrlQ1 <= 16'h0000;
            ctrlQ2 <= 16'h0000;
            ctrlQ3 <= 16'h0000;
        end
        else
        begin
            ctrlQ1 <= ctrlWord;
            ctrlQ2 <= ctrlQ1;
            ctrlQ3 <= ctrlQ2;
        end
    end

    // Polled change detection; a held request is answered only once
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            lastReq <= 4'h0;
            lastAck <= 1'b0;
        end
        else if (ctrlStable)
        begin
            lastReq <= ctrlQ2[fbalsm_pkg::STATE_MSB:fbalsm_pkg::STATE_LSB];
            lastAck <= ctrlQ2[fbalsm_pkg::FLAG_BIT];
        end
    end

    assign req        = ctrlQ2[fbalsm_pkg::STATE_MSB:fbalsm_pkg::STATE_LSB];
    assign ctrlStable = (ctrlQ2 == ctrlQ3); // Mixed old and new bits never pass
    assign reqSeen    = ctrlStable && (req != lastReq) && (req != 4'h0);
    assign ackRise    = ctrlStable && ctrlQ2[fbalsm_pkg::FLAG_BIT] && !lastAck;
    assign validReq   = (req == fbalsm_pkg::ST_INIT) || (req == fbalsm_pkg::ST_PREOP)
        || (req == fbalsm_pkg::ST_BOOT) || (req == fbalsm_pkg::ST_SAFEOP)
        || (req == fbalsm_pkg::ST_OP);

    // Transition decision; error leaves state unchanged
    always_comb
    begin
        next_state   = state;
        next_errFlag = errFlag;
        next_code    = errorCode;
        if (ackRise)
        begin
            next_errFlag = 1'b0;
            next_code    = fbalsm_pkg::CODE_NONE;
        end
        if (reqSeen)
        begin
            next_errFlag = 1'b0;
            next_code    = fbalsm_pkg::CODE_NONE;
            if (!validReq)
            begin
                next_errFlag = 1'b1;
                next_code    = fbalsm_pkg::CODE_BADTRANS;
            end
            else
            begin
                case (state)
                    S_INIT:
                    begin
                        if (req == fbalsm_pkg::ST_SAFEOP || req == fbalsm_pkg::ST_OP)
                        begin
                            next_errFlag = 1'b1;
                            next_code    = fbalsm_pkg::CODE_BADTRANS;
                        end
                        else if (req == fbalsm_pkg::ST_PREOP)
                        begin
                            if (smOk(smCfg0) && smOk(smCfg1))
                                next_state = S_PREOP;
                            else
                            begin
                                next_errFlag = 1'b1;
                                next_code    = fbalsm_pkg::CODE_BADSYNC;
                            end
                        end
                        else if (req == fbalsm_pkg::ST_BOOT)
                            next_state = S_BOOT;
                    end
                    S_PREOP:
                    begin
                        if (req == fbalsm_pkg::ST_OP || req == fbalsm_pkg::ST_BOOT)
                        begin
                            next_errFlag = 1'b1;
                            next_code    = fbalsm_pkg::CODE_BADTRANS;
                        end
                        else if (req == fbalsm_pkg::ST_SAFEOP)
                        begin
                            if (smOk(smCfg2) && smOk(smCfg3))
                                next_state = S_SAFEOP;
                            else
                            begin
                                next_errFlag = 1'b1;
                                next_code    = fbalsm_pkg::CODE_BADSYNC;
                            end
                        end
                        else if (req == fbalsm_pkg::ST_INIT)
                            next_state = S_INIT;
                    end
                    S_BOOT:
                    begin
                        // Bootstrap leaves only towards init
                        if (req == fbalsm_pkg::ST_INIT)
                            next_state = S_INIT;
                        else if (req != fbalsm_pkg::ST_BOOT)
                        begin
                            next_errFlag = 1'b1;
                            next_code    = fbalsm_pkg::CODE_BADTRANS;
                        end
                    end
                    S_SAFEOP:
                    begin
                        if (req == fbalsm_pkg::ST_BOOT)
                        begin
                            next_errFlag = 1'b1;
                            next_code    = fbalsm_pkg::CODE_BADTRANS;
                        end
                        else if (req == fbalsm_pkg::ST_OP)
                            next_state = S_OP;
                        else if (req == fbalsm_pkg::ST_PREOP)
                            next_state = S_PREOP;
                        else if (req == fbalsm_pkg::ST_INIT)
                            next_state = S_INIT;
                    end
                    S_OP:
                    begin
                        if (req == fbalsm_pkg::ST_BOOT)
                        begin
                            next_errFlag = 1'b1;
                            next_code    = fbalsm_pkg::CODE_BADTRANS;
                        end
                        else if (req == fbalsm_pkg::ST_SAFEOP)
                            next_state = S_SAFEOP;
                        else if (req == fbalsm_pkg::ST_PREOP)
                            next_state = S_PREOP;
                        else if (req == fbalsm_pkg::ST_INIT)
                            next_state = S_INIT;
                    end
                    default:
                        next_state = S_INIT;
                endcase
            end
        end
    end

    // State, error flag and code registers; only this block writes them
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state       <= S_INIT;
            errFlag     <= 1'b0;
            stateReport <= fbalsm_pkg::REPORT_RST;
            errorCode   <= fbalsm_pkg::CODE_RST;
            answerWe    <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            errFlag     <= next_errFlag;
            stateReport <= {11'h000, next_errFlag, stCode(next_state)};
            errorCode   <= next_code;
            answerWe    <= reqSeen || ackRise;
        end
    end

    // Per-state activity enables, registered so outputs come from flops
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            mailboxEn   <= 1'b0;
            cyclicInEn  <= 1'b0;
            cyclicOutEn <= 1'b0;
            torqueAllow <= 1'b0;
            eepromEmuEn <= 1'b1;
            sm0EventEn  <= 1'b0;
            syncSeek    <= 1'b0;
        end
        else
        begin
            eepromEmuEn <= (next_state == S_INIT);
            mailboxEn   <= (next_state == S_PREOP) || (next_state == S_SAFEOP)
                || (next_state == S_OP);
            sm0EventEn  <= (next_state == S_PREOP) || (next_state == S_SAFEOP)
                || (next_state == S_OP);
            cyclicInEn  <= (next_state == S_SAFEOP) || (next_state == S_OP);
            syncSeek    <= (next_state == S_SAFEOP) || (next_state == S_OP);
            cyclicOutEn <= (next_state == S_OP);
            // Torque only while actually synchronised
            torqueAllow <= (next_state == S_OP) && inSync;
        end
    end

    // Interrupt enable follows entry to and exit from op only
    always_ff @(posedge mclk)
    begin
        if (srst)
            sm2IrqEn <= 1'b0;
        else if (state == S_SAFEOP && next_state == S_OP)
            sm2IrqEn <= 1'b1;
        else if (state == S_OP && next_state != S_OP)
            sm2IrqEn <= 1'b0;
    end

    sequence reqForbiddenInit;
        reqSeen && state == S_INIT && (req == fbalsm_pkg::ST_OP || req == fbalsm_pkg::ST_SAFEOP);
    endsequence

    a_forbid_code: assert property (@(posedge mclk) disable iff (srst)
        reqForbiddenInit |=> errorCode == fbalsm_pkg::CODE_BADTRANS && stateReport[4]
            && stateReport[3:0] == fbalsm_pkg::ST_INIT)
        else $error("forbidden request not refused");
    a_code_legal: assert property (@(posedge mclk) disable iff (srst)
        errorCode == fbalsm_pkg::CODE_NONE || errorCode == fbalsm_pkg::CODE_BADTRANS
            || errorCode == fbalsm_pkg::CODE_BADSYNC)
        else $error("illegal error code");
    a_flag_code: assert property (@(posedge mclk) disable iff (srst)
        stateReport[fbalsm_pkg::FLAG_BIT] == (errorCode != fbalsm_pkg::CODE_NONE))
        else $error("flag and code disagree");
    a_ack_clear: assert property (@(posedge mclk) disable iff (srst)
        ackRise && !reqSeen |=> !stateReport[4] && errorCode == 16'h0000)
        else $error("acknowledge did not clear error");
    a_sync_bad: assert property (@(posedge mclk) disable iff (srst)
        reqSeen && state == S_INIT && req == fbalsm_pkg::ST_PREOP && !smOk(smCfg0)
            |=> errorCode == fbalsm_pkg::CODE_BADSYNC)
        else $error("bad sync setup accepted");
    a_irq_on: assert property (@(posedge mclk) disable iff (srst)
        $rose(state == S_OP) |=> sm2IrqEn)
        else $error("interrupt not enabled in op");
    a_irq_off: assert property (@(posedge mclk) disable iff (srst)
        $fell(state == S_OP) |=> !sm2IrqEn)
        else $error("interrupt left on after op");
    a_answer_each: assert property (@(posedge mclk) disable iff (srst)
        reqSeen |=> answerWe)
        else $error("request not answered");
    a_init_quiet: assert property (@(posedge mclk) disable iff (srst)
        stateReport[3:0] == fbalsm_pkg::ST_INIT |-> !mailboxEn && !cyclicInEn && eepromEmuEn)
        else $error("traffic in init");
    a_settle_first: assert property (@(posedge mclk) disable iff (srst)
        !ctrlStable |=> !answerWe)
        else $error("answer from an unsettled control word");
    a_torque_sync: assert property (@(posedge mclk) disable iff (srst)
        torqueAllow |-> $past(inSync) && stateReport[3:0] == fbalsm_pkg::ST_OP)
        else $error("torque allowed outside synchronised op");
    a_op_irq: assert property (@(posedge mclk) disable iff (srst)
        cyclicOutEn |-> sm2IrqEn && stateReport[3:0] == fbalsm_pkg::ST_OP)
        else $error("setpoints processed without op interrupt");
endmodule

/* verification/fbalsm_master_model.sv */
// Network master side: writes state requests and acknowledgements
module fbalsm_master_model (
    input  wire logic        mclk,    // System clock
    output logic      [15:0] ctrlWord // Control register as the master writes it
);
    timeunit 1ns;
    timeprecision 1ps;

    int held = 3;

    // Only the master writes this word; the device reads it
    initial ctrlWord = 16'h0000;

    // Cycles the present value has stood; the device needs three to sync it
    always @(posedge mclk)
        held <= held + 1;

    // Change just after a falling edge, never before the hold has run out
    task automatic put(input logic [15:0] value);
        while (held < 3)
            @(negedge mclk);
        @(negedge mclk);
        ctrlWord = value;
        held = 0;
    endtask

    task automatic request(input logic [3:0] code);
        put({ctrlWord[15:4], code});
    endtask

    task automatic ack(input logic level);
        put({ctrlWord[15:5], level, ctrlWord[3:0]});
    endtask
endmodule

/* verification/test_fieldbus_al_state_machine.sv */
module test_fieldbus_al_state_machine;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MIN_ADDR = 16'h1000;
    localparam logic [15:0] MAX_LEN  = 16'h0200;
    logic                        mclk = 1'b0;
    logic                        srst = 1'b1;
    logic                 [15:0] ctrlWord;
    fbalsm_pkg::fbalsm_smcfg_s   smCfg [4];
    logic                        inSync = 1'b0;
    logic [15:0] stateReport, errorCode;
    logic answerWe, mailboxEn, cyclicInEn, cyclicOutEn, torqueAllow;
    logic eepromEmuEn, sm0EventEn, sm2IrqEn, syncSeek;
    int miscompares = 0;
    int checked = 0;
    logic [3:0] curState, lastReq, code;
    logic errFlag;
    logic [15:0] lastCode;
    logic [7:0] dir [24] = '{8'h30, 8'h20, 8'h10, 8'h40, 8'h80, 8'h50, 8'h22, 8'h10,
        8'h20, 8'h20, 8'h80, 8'h30, 8'h48, 8'h00, 8'h40, 8'h30, 8'h80, 8'h30, 8'h40,
        8'h80, 8'h20, 8'h40, 8'h80, 8'h10};
    logic [3:0] pool [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h4, 4'h8, 4'hc};

    always #2 mclk = ~mclk;

    fbalsm_top dut (
        .mclk(mclk), .srst(srst), .ctrlWord(ctrlWord), .smCfg0(smCfg[0]),
        .smCfg1(smCfg[1]), .smCfg2(smCfg[2]), .smCfg3(smCfg[3]), .inSync(inSync),
        .stateReport(stateReport), .errorCode(errorCode), .answerWe(answerWe),
        .mailboxEn(mailboxEn), .cyclicInEn(cyclicInEn), .cyclicOutEn(cyclicOutEn),
        .torqueAllow(torqueAllow), .eepromEmuEn(eepromEmuEn), .sm0EventEn(sm0EventEn),
        .sm2IrqEn(sm2IrqEn), .syncSeek(syncSeek)
    );

    fbalsm_master_model master (
        .mclk(mclk),
        .ctrlWord(ctrlWord)
    );

    // A setup is usable only if it starts high enough and fits without wrapping
    function automatic logic smOk(input fbalsm_pkg::fbalsm_smcfg_s f);
        return f.startAddr >= MIN_ADDR && f.length != 16'h0000 && f.length <= MAX_LEN
            && (17'(f.startAddr) + 17'(f.length) < 17'h10000);
    endfunction

    // Code the device must answer with for one request
    function automatic logic [15:0] expCode(input logic [3:0] cur, input logic [3:0] req,
                                            input logic ok01, input logic ok23);
        if (!(req inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8}))
            return fbalsm_pkg::CODE_BADTRANS;
        if (req == cur)
            return fbalsm_pkg::CODE_NONE;
        if (cur == fbalsm_pkg::ST_BOOT)
            return (req == fbalsm_pkg::ST_INIT) ? fbalsm_pkg::CODE_NONE
                                                : fbalsm_pkg::CODE_BADTRANS;
        if (req == fbalsm_pkg::ST_BOOT && cur != fbalsm_pkg::ST_INIT)
            return fbalsm_pkg::CODE_BADTRANS;
        if (cur == fbalsm_pkg::ST_INIT && req inside {4'h4, 4'h8})
            return fbalsm_pkg::CODE_BADTRANS;
        if (cur == fbalsm_pkg::ST_PREOP && req == fbalsm_pkg::ST_OP)
            return fbalsm_pkg::CODE_BADTRANS;
        if ((cur == fbalsm_pkg::ST_INIT && req == fbalsm_pkg::ST_PREOP && !ok01)
            || (cur == fbalsm_pkg::ST_PREOP && req == fbalsm_pkg::ST_SAFEOP && !ok23))
            return fbalsm_pkg::CODE_BADSYNC;
        return fbalsm_pkg::CODE_NONE;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Bit i of mask makes setup i unusable, picking one of the two ways to fail at random
    task automatic setCfg(input logic [3:0] mask);
        for (int i = 0; i < 4; i++)
        begin
            smCfg[i].startAddr = MIN_ADDR + 16'($urandom_range(0, 16'h7000));
            smCfg[i].length = 16'($urandom_range(1, MAX_LEN));
            if (mask[i] && $urandom_range(0, 1) == 0)
                smCfg[i].startAddr = MIN_ADDR - 16'h0001;
            else if (mask[i])
                smCfg[i].length = MAX_LEN + 16'h0001;
        end
    endtask

    // Per-state enables, looked at once the answer has landed
    task automatic chkOutputs();
        logic inOp;
        inOp = (curState == fbalsm_pkg::ST_OP);
        chk("sm2 interrupt", 16'(inOp), 16'(sm2IrqEn));
        chk("torque allow", 16'(inOp && inSync), 16'(torqueAllow));
        if (curState == fbalsm_pkg::ST_INIT)
            chk("init", 16'h0008, 16'({eepromEmuEn, mailboxEn, cyclicInEn, cyclicOutEn}));
        if (curState == fbalsm_pkg::ST_PREOP)
            chk("preop enables", 16'h0003, {14'h0, mailboxEn, sm0EventEn});
        if (curState == fbalsm_pkg::ST_SAFEOP)
            chk("safeop enables", 16'h0003, {14'h0, cyclicInEn, syncSeek});
        if (curState == fbalsm_pkg::ST_OP)
            chk("op setpoints", 16'h0001, 16'(cyclicOutEn));
    endtask

    task automatic waitAnswer(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 10 && !seen; i++)
        begin
            @(negedge mclk);
            seen = (answerWe === 1'b1);
        end
    endtask

    task automatic doReq(input logic [3:0] req);
        logic seen;
        logic [15:0] ec;
        ec = expCode(curState, req, smOk(smCfg[0]) && smOk(smCfg[1]),
                     smOk(smCfg[2]) && smOk(smCfg[3]));
        master.request(req);
        waitAnswer(seen);
        if (req == lastReq || req == 4'h0)
            chk("refused request answer", 16'h0000, 16'(seen));
        else
        begin
            chk("answer strobe", 16'h0001, 16'(seen));
            if (!seen)
                give_verdict();
            if (ec == fbalsm_pkg::CODE_NONE)
                curState = req;
            errFlag = (ec != fbalsm_pkg::CODE_NONE);
            lastCode = ec;
            chk("state report", {11'h0, errFlag, curState}, stateReport);
            chk("error code", ec, errorCode);
            chkOutputs();
        end
        lastReq = req;
    endtask

    // A falling acknowledgement must leave the error; a rising one clears it
    task automatic doAck();
        if (ctrlWord[4] === 1'b1)
        begin
            master.ack(1'b0);
            repeat (6) @(negedge mclk);
            chk("flag after falling ack", {11'h0, errFlag, curState}, stateReport);
            chk("code after falling ack", lastCode, errorCode);
        end
        master.ack(1'b1);
        repeat (6) @(negedge mclk);
        errFlag = 1'b0;
        lastCode = fbalsm_pkg::CODE_NONE;
        chk("flag after ack", {12'h0, curState}, stateReport);
        chk("code after ack", 16'h0000, errorCode);
    endtask

    initial
    begin
        void'($urandom(41225));
        setCfg(4'h0);
        curState = fbalsm_pkg::ST_INIT;
        lastReq = 4'h0;
        errFlag = 1'b0;
        lastCode = 16'h0000;
        repeat (10) @(negedge mclk);
        srst = 1'b0;
        chk("reset report", fbalsm_pkg::REPORT_RST, stateReport);
        chk("reset code", fbalsm_pkg::CODE_RST, errorCode);
        chk("reset strobe", 16'h0000, 16'(answerWe));
        chkOutputs();
        $display("test reset done");
        // Every code, every forbidden step except boot to safeop and boot to op, both bad setups, refusals
        inSync = 1'b1;
        foreach (dir[i])
        begin
            setCfg(dir[i][3:0]);
            doReq(dir[i][7:4]);
            if (errFlag)
                doAck();
        end
        $display("test directed transitions done");
        for (int n = 0; n < 300; n++)
        begin
            setCfg(($urandom_range(0, 3) == 0) ? 4'($urandom) : 4'h0);
            inSync = 1'($urandom);
            code = ($urandom_range(0, 19) == 0) ? 4'h0 : pool[$urandom_range(0, 7)];
            doReq(code);
            if (errFlag && $urandom_range(0, 1) == 1)
                doAck();
        end
        $display("test random transitions done");
        give_verdict();
    end
endmodule
